// [fbp_pkg.sv]
// Shared constants, command codes and carrier types for the flash protection controller
package fbp_pkg;

	localparam int CLK_NS = 20;
	localparam int ADDR_W = 22;
	localparam int DATA_W = 16;

	// Settings register layout
	localparam int PSR_SECID_BIT = 0;
	localparam int PSR_MODE_LO   = 1;
	localparam int PSR_MODE_HI   = 2;
	localparam int PSR_VDEF_BIT  = 4;
	localparam logic [DATA_W-1:0] PSR_RSVD_MASK  = 16'hFFE8;
	localparam logic [1:0]        MODE_PASS_DFLT = 2'h3;
	localparam logic [1:0]        MODE_PASS_ONLY = 2'h2;
	localparam logic [1:0]        MODE_PWD_ONLY  = 2'h1;
	localparam logic [1:0]        MODE_ILLEGAL   = 2'h0;

	// Bus timing in ns, persistent program and erase times in us and ms, and derived cycle counts
	localparam int T_WE_LOW_NS  = 40;
	localparam int T_ACC_NS     = 70;
	localparam int T_RST_LOW_NS = 500;
	localparam int T_RST_REC_NS = 50;
	localparam int PERSISTENT_BLOCK_GUARD_BIT_PROG_US = 20;
	localparam int PERSISTENT_BLOCK_GUARD_BIT_ERASE_MS = 25;
	localparam int WP_CYC  = (T_WE_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int ACC_CYC = (T_ACC_NS + CLK_NS - 1) / CLK_NS;
	localparam int RP_CYC  = (T_RST_LOW_NS + CLK_NS - 1) / CLK_NS;
	localparam int RH_CYC  = (T_RST_REC_NS + CLK_NS - 1) / CLK_NS;
	localparam int PERSISTENT_BLOCK_GUARD_BIT_PROG_CYC = (PERSISTENT_BLOCK_GUARD_BIT_PROG_US * 1000 + CLK_NS - 1) / CLK_NS;
	localparam int PERSISTENT_BLOCK_GUARD_BIT_ERASE_CYC = (PERSISTENT_BLOCK_GUARD_BIT_ERASE_MS * 1000000 + CLK_NS - 1) / CLK_NS;
	// Pin output flop plus three-stage input synchroniser
	localparam int SYNC_CYC = 4;
	localparam int TMR_W    = 21;
	localparam int CNT_W    = 8;

	// Command cycle codes, all arbitrary
	localparam logic [ADDR_W-1:0] CMD_ADDR  = 22'h000555;
	localparam logic [ADDR_W-1:0] ZERO_ADDR = 22'h000000;
	localparam logic [DATA_W-1:0] CODE_PSR_ENTRY  = 16'h0075;
	localparam logic [DATA_W-1:0] CODE_VPB_ENTRY  = 16'h00E0;
	localparam logic [DATA_W-1:0] CODE_PERSISTENT_BLOCK_GUARD_BIT_ENTRY = 16'h00C0;
	localparam logic [DATA_W-1:0] CODE_GLB_ENTRY  = 16'h0050;
	localparam logic [DATA_W-1:0] CODE_EXIT       = 16'h00F0;
	localparam logic [DATA_W-1:0] CODE_BIT_ZERO   = 16'h0000;
	localparam logic [DATA_W-1:0] CODE_BIT_ONE    = 16'h0001;
	localparam logic [DATA_W-1:0] CODE_NV_ERASE   = 16'h0030;

	typedef enum logic [3:0] {
		OP_PSR_PROG,
		OP_PSR_READ,
		OP_VPB_SET,
		OP_VPB_CLR,
		OP_VPB_READ,
		OP_PERSISTENT_BLOCK_GUARD_BIT_PROG,
		OP_PERSISTENT_BLOCK_GUARD_BIT_ERASE,
		OP_PERSISTENT_BLOCK_GUARD_BIT_READ,
		OP_GLB_SET,
		OP_GLB_READ,
		OP_HW_RESET
	} fbp_op_e;

	typedef struct packed {
		fbp_op_e             op;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   data;
	} fbp_req_s;

	typedef struct packed {
		logic                ce_n;
		logic                oe_n;
		logic                we_n;
		logic                rst_n;
		logic                dq_oe_n;
		logic [ADDR_W-1:0]   addr;
		logic [DATA_W-1:0]   dq;
	} fbp_pins_s;

endpackage

// [fbp_ctrl.sv]
// Host controller that drives flash protection command sequences over the flash bus
// Operation
// (RULE1) Settings register is sixteen bits, four one-time bits, zeros never return to one.
// (RULE2) Settings bits 15..5 and 3 are reserved and read as ones.
// (RULE3) Settings bit 4 chooses volatile default: zero protected, one unprotected.
// (RULE4) Settings bit 0 locks the security ID space when zero.
// (RULE5) Settings bits 2..1: 11 default, 10 pass-through only, 01 password only.
// (RULE6) A settings program leaving bits 2..1 at 00 is rejected.
// (RULE7) Settings mode is entered by entry command and left by exit command.
// (RULE8) One volatile guard bit per 32 KWord block, boot halves separate; the model keys all 128 bits on address bits 21..15 alone.
// (RULE9) Volatile mode accepts set, clear, status read until exit command.
// (RULE10) Volatile bit zero blocks program and erase; one allows them.
// (RULE11) Hardware reset loads every volatile bit from settings bit 4.
// (RULE12) One persistent guard bit per block, all ones as shipped.
// (RULE13) Persistent program clears one block bit within 20 microseconds.
// (RULE14) Persistent erase sets all bits to one, up to 25 milliseconds.
// (RULE15) Persistent mode offers a status read of one block bit.
// (RULE16) Persistent bits survive hardware reset and power cycling.
// (RULE17) After irreversible lock, persistent program and erase are ignored.
// (RULE18) Global lock zero freezes persistent bits; one allows change in mode.
// (RULE19) Global lock mode: set drives bit to zero, status read, exit.
// (RULE20) Pass-through: reset or power cycle clears global lock to one.
// (RULE21) Host should pick explicit pass-through only or password only; the controller also accepts 11 and leaves the choice to the caller.
// (RULE22) Password mode: lock zero after reset, one only after password check.
// (RULE23) Settings program in password mode drives global lock to zero.
// (RULE24) Block is protected when either guard bit is zero.
// (RULE25) Every mode step is a sequence of host write cycles on the bus; status reads use a read cycle with OE low instead.
`timescale 1ns/1ps
module fbp_ctrl #(
	parameter int ERASE_CYC = fbp_pkg::PERSISTENT_BLOCK_GUARD_BIT_ERASE_CYC
) (
	input  wire logic                        i_clk_sys,
	input  wire logic                        i_reset_n,
	input  wire logic                        i_req_valid,
	input  wire fbp_pkg::fbp_req_s           i_req,
	output logic                             o_req_ready,
	output logic                             o_busy,
	output logic                             o_done,
	output logic                             o_refused,
	output logic [fbp_pkg::DATA_W-1:0]       o_rdata,
	output logic                             o_flash_ce_n,
	output logic                             o_flash_oe_n,
	output logic                             o_flash_we_n,
	output logic                             o_flash_rst_n,
	output logic [fbp_pkg::ADDR_W-1:0]       o_flash_addr,
	output logic [fbp_pkg::DATA_W-1:0]       o_flash_dq,
	output logic                             o_flash_dq_oe_n,
	input  wire logic [fbp_pkg::DATA_W-1:0]  i_flash_dq
);
	import fbp_pkg::*;

	typedef enum logic [2:0] {
		ST_IDLE,
		ST_ENTRY,
		ST_OP,
		ST_READ,
		ST_WAIT,
		ST_EXIT,
		ST_RST,
		ST_RREC
	} fbp_state_e;

	fbp_state_e            state_reg, state_next;
	logic [CNT_W-1:0]      cnt_reg, cnt_next;
	logic [TMR_W-1:0]      tmr_reg, tmr_next;
	fbp_req_s              req_reg, req_next;
	logic [DATA_W-1:0]     rdata_reg, rdata_next;
	logic                  done_reg, done_next;
	logic                  refused_reg, refused_next;
	fbp_pins_s             pins_reg, pins_next;
	logic [DATA_W-1:0]     dq_s1_reg, dq_s2_reg, dq_s3_reg;
	logic                  accept;
	logic                  psr_bad;

	function automatic logic is_read(input fbp_op_e op);
		return (op == OP_PSR_READ) || (op == OP_VPB_READ) || (op == OP_PERSISTENT_BLOCK_GUARD_BIT_READ)
			|| (op == OP_GLB_READ);
	endfunction

	function automatic logic [DATA_W-1:0] entry_code(input fbp_op_e op);
		unique case (op)
			OP_PSR_PROG, OP_PSR_READ:                  return CODE_PSR_ENTRY;
			OP_VPB_SET, OP_VPB_CLR, OP_VPB_READ:       return CODE_VPB_ENTRY;
			OP_PERSISTENT_BLOCK_GUARD_BIT_PROG, OP_PERSISTENT_BLOCK_GUARD_BIT_ERASE, OP_PERSISTENT_BLOCK_GUARD_BIT_READ: return CODE_PERSISTENT_BLOCK_GUARD_BIT_ENTRY;
			OP_GLB_SET, OP_GLB_READ, OP_HW_RESET:      return CODE_GLB_ENTRY;
			default:                                   return CODE_EXIT;
		endcase
	endfunction

	function automatic logic [DATA_W-1:0] op_code(input fbp_req_s r);
		unique case (r.op)
			OP_PSR_PROG:   return r.data;
			OP_VPB_CLR:    return CODE_BIT_ONE;
			OP_PERSISTENT_BLOCK_GUARD_BIT_ERASE: return CODE_NV_ERASE;
			default:       return CODE_BIT_ZERO;
		endcase
	endfunction

	// Illegal 00 pair is never sent; explicit choice left to the caller
	assign psr_bad = (i_req.op == OP_PSR_PROG)
		&& (i_req.data[PSR_MODE_HI:PSR_MODE_LO] == MODE_ILLEGAL); // RULE6 RULE21
	assign o_req_ready = (state_reg == ST_IDLE);
	assign accept = i_req_valid && o_req_ready && !psr_bad;
	assign o_busy = (state_reg != ST_IDLE);
	assign o_done = done_reg;
	assign o_refused = refused_reg;
	assign o_rdata = rdata_reg;
	assign o_flash_ce_n = pins_reg.ce_n;
	assign o_flash_oe_n = pins_reg.oe_n;
	assign o_flash_we_n = pins_reg.we_n;
	assign o_flash_rst_n = pins_reg.rst_n;
	assign o_flash_addr = pins_reg.addr;
	assign o_flash_dq = pins_reg.dq;
	assign o_flash_dq_oe_n = pins_reg.dq_oe_n;

	always_comb
	begin
		state_next = state_reg;
		cnt_next = cnt_reg + 1'b1;
		tmr_next = tmr_reg;
		req_next = req_reg;
		rdata_next = rdata_reg;
		done_next = 1'b0;
		refused_next = i_req_valid && o_req_ready && psr_bad; // RULE6
		unique case (state_reg)
			ST_IDLE:
			begin
				cnt_next = '0;
				if (accept)
				begin
					req_next = i_req;
					if (i_req.op == OP_HW_RESET)
					begin
						state_next = ST_RST;
						tmr_next = TMR_W'(RP_CYC - 1);
					end
					else
						state_next = ST_ENTRY; // RULE7 RULE9 RULE19
				end
			end
			ST_ENTRY:
				if (cnt_reg == CNT_W'(WP_CYC))
				begin
					cnt_next = '0;
					state_next = is_read(req_reg.op) ? ST_READ : ST_OP; // RULE15 RULE19
				end
			ST_OP:
				if (cnt_reg == CNT_W'(WP_CYC))
				begin
					cnt_next = '0;
					state_next = ST_EXIT;
					if (req_reg.op == OP_PERSISTENT_BLOCK_GUARD_BIT_PROG)
					begin
						state_next = ST_WAIT;
						tmr_next = TMR_W'(PERSISTENT_BLOCK_GUARD_BIT_PROG_CYC - 1); // RULE13
					end
					else if (req_reg.op == OP_PERSISTENT_BLOCK_GUARD_BIT_ERASE)
					begin
						state_next = ST_WAIT;
						tmr_next = TMR_W'(ERASE_CYC - 1); // RULE14
					end
				end
			ST_READ:
				// Data accepted only once two synchroniser stages agree
				if (cnt_reg >= CNT_W'(ACC_CYC + SYNC_CYC) && dq_s2_reg == dq_s3_reg)
				begin
					cnt_next = '0;
					rdata_next = dq_s3_reg;
					state_next = ST_EXIT;
				end
			ST_WAIT:
			begin
				cnt_next = '0;
				tmr_next = tmr_reg - 1'b1;
				if (tmr_reg == '0)
					state_next = ST_EXIT;
			end
			ST_EXIT:
				if (cnt_reg == CNT_W'(WP_CYC))
				begin
					state_next = ST_IDLE; // RULE7 RULE9
					done_next = 1'b1;
				end
			ST_RST:
			begin
				tmr_next = tmr_reg - 1'b1;
				if (tmr_reg == '0)
				begin
					state_next = ST_RREC;
					tmr_next = TMR_W'(RH_CYC - 1);
				end
			end
			ST_RREC:
			begin
				tmr_next = tmr_reg - 1'b1;
				if (tmr_reg == '0)
				begin
					state_next = ST_IDLE;
					done_next = 1'b1;
				end
			end
		endcase
	end

	// Pin values follow the registered state, so all pins move on one edge
	always_comb
	begin
		pins_next.ce_n = 1'b1;
		pins_next.oe_n = 1'b1;
		pins_next.we_n = 1'b1;
		pins_next.rst_n = 1'b1;
		pins_next.dq_oe_n = 1'b1;
		pins_next.addr = pins_reg.addr;
		pins_next.dq = pins_reg.dq;
		unique case (state_reg)
			ST_ENTRY, ST_OP, ST_EXIT:
			begin
				pins_next.ce_n = 1'b0;
				pins_next.dq_oe_n = 1'b0;
				pins_next.we_n = (cnt_reg >= CNT_W'(WP_CYC)); // RULE25
				pins_next.addr = (state_reg == ST_OP) ? req_reg.addr : CMD_ADDR;
				pins_next.dq = (state_reg == ST_ENTRY) ? entry_code(req_reg.op)
					: (state_reg == ST_OP) ? op_code(req_reg) : CODE_EXIT;
			end
			ST_READ:
			begin
				pins_next.ce_n = 1'b0;
				pins_next.oe_n = 1'b0;
				pins_next.addr = (req_reg.op == OP_GLB_READ || req_reg.op == OP_PSR_READ)
					? ZERO_ADDR : req_reg.addr;
			end
			// Volatile bits reload and pass-through lock clears on this pulse
			ST_RST: pins_next.rst_n = 1'b0; // RULE11 RULE20
			default: ;
		endcase
	end

	always_ff @(posedge i_clk_sys)
	begin
		if (!i_reset_n)
		begin
			state_reg <= ST_IDLE;
			cnt_reg <= '0;
			tmr_reg <= '0;
			req_reg <= '0;
			rdata_reg <= '0;
			done_reg <= 1'b0;
			refused_reg <= 1'b0;
			pins_reg <= '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1, rst_n: 1'b1,
				dq_oe_n: 1'b1, addr: '0, dq: '0};
			dq_s1_reg <= '0;
			dq_s2_reg <= '0;
			dq_s3_reg <= '0;
		end
		else
		begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			tmr_reg <= tmr_next;
			req_reg <= req_next;
			rdata_reg <= rdata_next;
			done_reg <= done_next;
			refused_reg <= refused_next;
			pins_reg <= pins_next;
			dq_s1_reg <= i_flash_dq;
			dq_s2_reg <= dq_s1_reg;
			dq_s3_reg <= dq_s2_reg;
		end
	end

	AST_REFUSE_00: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE6
		(i_req_valid && o_req_ready && psr_bad) |=> (o_refused && state_reg == ST_IDLE))
		else $error("Illegal mode pair not refused");
	AST_ENTRY_FIRST: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE7
		(accept && i_req.op != OP_HW_RESET) |=> ##1 (!o_flash_ce_n && o_flash_dq
			== entry_code(req_reg.op) && o_flash_addr == CMD_ADDR))
		else $error("Sequence did not open with the entry cycle");
	AST_EXIT_LAST: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE9
		(state_reg == ST_EXIT && cnt_reg == CNT_W'(WP_CYC)) |=> (o_done && !o_busy))
		else $error("Exit cycle did not finish the sequence");
	AST_PERSISTENT_BLOCK_GUARD_BIT_WAIT: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE13
		(state_reg == ST_OP && state_next == ST_WAIT && req_reg.op == OP_PERSISTENT_BLOCK_GUARD_BIT_PROG)
		|=> (tmr_reg == TMR_W'(PERSISTENT_BLOCK_GUARD_BIT_PROG_CYC - 1)))
		else $error("Persistent program wait not loaded");
	AST_ERASE_WAIT: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE14
		(state_reg == ST_OP && state_next == ST_WAIT && req_reg.op == OP_PERSISTENT_BLOCK_GUARD_BIT_ERASE)
		|=> (tmr_reg == TMR_W'(ERASE_CYC - 1)))
		else $error("Persistent erase wait not loaded");
	AST_RST_PULSE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE11
		$fell(o_flash_rst_n) |-> (!o_flash_rst_n) [*8])
		else $error("Reset pulse too short");
	AST_WE_PULSE: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE25
		$fell(o_flash_we_n) |=> !o_flash_we_n ##1 o_flash_we_n)
		else $error("Write pulse width wrong");
	AST_WRITE_DRIVES: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE25
		!o_flash_we_n |-> (!o_flash_dq_oe_n && !o_flash_ce_n && o_flash_oe_n))
		else $error("Write cycle without data drive");
	AST_NO_CONTENTION: assert property (@(posedge i_clk_sys) disable iff (!i_reset_n) // RULE15
		!o_flash_oe_n |-> o_flash_dq_oe_n)
		else $error("Data driven during read");

endmodule

// [fbp_flash_model.sv]
// Behavioural flash device model holding the protection state
`timescale 1ns/1ps
module fbp_flash_model #(
	parameter bit IRREV_LOCKED = 1'b0
) (
	input  wire logic                       i_ce_n,
	input  wire logic                       i_oe_n,
	input  wire logic                       i_we_n,
	input  wire logic                       i_rst_n,
	input  wire logic                       i_slow,
	input  wire logic [fbp_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [fbp_pkg::DATA_W-1:0] i_dq,
	output logic      [fbp_pkg::DATA_W-1:0] o_dq
);
	import fbp_pkg::*;
	logic [DATA_W-1:0] settings_reg = 16'hFFFF;
	logic [127:0]      vol_reg      = '1;
	logic [127:0]      pers_reg     = '1;
	logic              lock_reg     = 1'b1;
	logic [2:0]        mode_reg     = 3'h0;
	logic [DATA_W-1:0] last_reg     = 16'h0000;
	logic [DATA_W-1:0] rd_val;
	logic              rd_ok        = 1'b0;
	logic [6:0]        blk;
	assign blk = i_addr[21:15];
	// Command cycles latch on the rising write strobe
	always @(posedge i_we_n)
	begin
		if (!i_ce_n && i_rst_n)
		begin
			if (mode_reg != 3'h0 && i_addr == CMD_ADDR && i_dq == CODE_EXIT)
				mode_reg = 3'h0;
			else if (mode_reg == 3'h0 && i_addr == CMD_ADDR)
				mode_reg = (i_dq == CODE_PSR_ENTRY) ? 3'h1 : (i_dq == CODE_VPB_ENTRY) ? 3'h2 :
					(i_dq == CODE_PERSISTENT_BLOCK_GUARD_BIT_ENTRY) ? 3'h3 : (i_dq == CODE_GLB_ENTRY) ? 3'h4 : 3'h0;
			else if (mode_reg == 3'h1 && (settings_reg[2:1] & i_dq[2:1]) != MODE_ILLEGAL)
			begin
				settings_reg = settings_reg & (i_dq | PSR_RSVD_MASK);
				if (settings_reg[2:1] == MODE_PWD_ONLY)
					lock_reg = 1'b0;
			end
			else if (mode_reg == 3'h2)
				vol_reg[blk] = i_dq[0];
			else if (mode_reg == 3'h3 && lock_reg && !IRREV_LOCKED)
			begin
				if (i_dq == CODE_NV_ERASE)
					pers_reg = '1;
				else
					pers_reg[blk] = 1'b0;
			end
			else if (mode_reg == 3'h4)
				lock_reg = 1'b0;
		end
	end
	// Persistent bits untouched by reset
	always @(negedge i_rst_n)
	begin
		vol_reg  = {128{settings_reg[PSR_VDEF_BIT]}};
		lock_reg = settings_reg[2:1] != MODE_PWD_ONLY;
		mode_reg = 3'h0;
	end
	always @*
	begin
		case (mode_reg)
			3'h1: rd_val = settings_reg | PSR_RSVD_MASK;
			3'h2: rd_val = {15'h0000, vol_reg[blk]};
			3'h3: rd_val = {15'h0000, pers_reg[blk]};
			3'h4: rd_val = {15'h0000, lock_reg};
			default: rd_val = {15'h0000, vol_reg[blk] & pers_reg[blk]};
		endcase
	end
	// Data valid only after access time; otherwise an inverted stale word
	// Slow part takes the full access time; parts up to just under 120 ns still read, as the host waits for two synchroniser stages to agree
	always @(i_oe_n or i_addr)
	begin
		rd_ok = 1'b0;
		if (!i_oe_n)
			rd_ok <= #(i_slow ? T_ACC_NS : 30) 1'b1;
	end
	always @(posedge rd_ok)
		last_reg = rd_val;
	assign o_dq = (rd_ok && !i_ce_n && !i_oe_n) ? rd_val : ~last_reg;
endmodule

// [fbp_ctrl_tb.sv]
// Self-checking testbench for the flash protection controller
`timescale 1ns/1ps
module fbp_ctrl_tb;
	import fbp_pkg::*;
	typedef struct packed {fbp_req_s req; logic [DATA_W-1:0] exp;} fbp_row_s;
	logic              clk_sys = 1'b0;
	logic              reset_n = 1'b0;
	logic              valid   = 1'b0;
	logic              slow    = 1'b0;
	fbp_req_s          req     = '{OP_PSR_READ, 22'h0, 16'h0};
	logic              ready, busy, done, refused, ce_n, oe_n, we_n, rst_n, dq_oe_n, refd;
	logic [DATA_W-1:0] rdata, host_dq, mdl_dq;
	logic [ADDR_W-1:0] addr;
	int                fail_count  = 0;
	int                comparisons = 0;
	localparam logic [ADDR_W-1:0] B1 = 22'h008000;
	localparam logic [ADDR_W-1:0] B2 = 22'h010000;
	fbp_row_s rows[16] = '{
		'{'{OP_PSR_READ, 22'h0, 16'h0}, 16'hFFFF}, '{'{OP_GLB_READ, 22'h0, 16'h0}, 16'h0001},
		'{'{OP_VPB_READ, B1, 16'h0}, 16'h0001}, '{'{OP_VPB_SET, B1, 16'h0}, 16'h0},
		'{'{OP_VPB_READ, B1, 16'h0}, 16'h0000}, '{'{OP_VPB_CLR, B1, 16'h0}, 16'h0},
		'{'{OP_VPB_READ, B1, 16'h0}, 16'h0001}, '{'{OP_PERSISTENT_BLOCK_GUARD_BIT_PROG, B1, 16'h0}, 16'h0},
		'{'{OP_PERSISTENT_BLOCK_GUARD_BIT_READ, B1, 16'h0}, 16'h0000}, '{'{OP_PERSISTENT_BLOCK_GUARD_BIT_READ, B2, 16'h0}, 16'h0001},
		'{'{OP_PERSISTENT_BLOCK_GUARD_BIT_ERASE, B1, 16'h0}, 16'h0}, '{'{OP_PERSISTENT_BLOCK_GUARD_BIT_READ, B1, 16'h0}, 16'h0001},
		'{'{OP_PSR_PROG, 22'h0, 16'hFFFE}, 16'h0}, '{'{OP_PSR_READ, 22'h0, 16'h0}, 16'hFFFE},
		'{'{OP_PSR_PROG, 22'h0, 16'hFFFF}, 16'h0}, '{'{OP_PSR_READ, 22'h0, 16'h0}, 16'hFFFE}};
	always #10 clk_sys = ~clk_sys;
	fbp_ctrl #(.ERASE_CYC(50)) u_dut (.i_clk_sys(clk_sys), .i_reset_n(reset_n),
		.i_req_valid(valid), .i_req(req), .o_req_ready(ready), .o_busy(busy), .o_done(done),
		.o_refused(refused), .o_rdata(rdata), .o_flash_ce_n(ce_n), .o_flash_oe_n(oe_n),
		.o_flash_we_n(we_n), .o_flash_rst_n(rst_n), .o_flash_addr(addr), .o_flash_dq(host_dq),
		.o_flash_dq_oe_n(dq_oe_n), .i_flash_dq(dq_oe_n ? mdl_dq : host_dq));
	fbp_flash_model u_flash (.i_ce_n(ce_n), .i_oe_n(oe_n), .i_we_n(we_n), .i_rst_n(rst_n),
		.i_slow(slow), .i_addr(addr), .i_dq(dq_oe_n ? mdl_dq : host_dq), .o_dq(mdl_dq));
	task automatic check(input string nm, input logic [DATA_W-1:0] e, input logic [DATA_W-1:0] g);
		comparisons++;
		if (g !== e)
		begin
			fail_count++;
			$display("unexpected %s: expected %h, seen %h", nm, e, g);
		end
	endtask
	// Entered and left just after a rising edge; request held until taken
	task automatic do_op(input fbp_op_e op, input logic [ADDR_W-1:0] a,
		input logic [DATA_W-1:0] d);
		int n;
		n = 0;
		req = '{op, a, d};
		valid = 1'b1;
		while (ready !== 1'b1)
			@(posedge clk_sys) #2;
		@(posedge clk_sys) #2;
		valid = 1'b0;
		while (done !== 1'b1 && refused !== 1'b1 && n < 2000)
		begin
			@(posedge clk_sys) #2;
			n++;
		end
		check("completion", 16'h1, {15'h0, n < 2000});
		refd = refused;
		@(posedge clk_sys) #2;
	endtask
	task automatic stop_test;
		$display("comparisons %0d, mismatches %0d", comparisons, fail_count);
		if (fail_count == 0 && comparisons > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	initial
	begin
		#(60000 * CLK_NS);
		fail_count++;
		stop_test();
	end
	initial
	begin
		repeat (6) @(posedge clk_sys);
		#2 reset_n = 1'b1;
		foreach (rows[i])
		begin
			do_op(rows[i].req.op, rows[i].req.addr, rows[i].req.data);
			if (rows[i].req.op inside {OP_PSR_READ, OP_VPB_READ, OP_PERSISTENT_BLOCK_GUARD_BIT_READ, OP_GLB_READ})
				check("read word", rows[i].exp, rdata);
			$display("row %0d done", i);
		end
		do_op(OP_PSR_PROG, 22'h0, 16'hFFF8);
		check("refused", 16'h1, {15'h0, refd});
		do_op(OP_PSR_PROG, 22'h0, 16'hFFEC);
		do_op(OP_PSR_READ, 22'h0, 16'h0);
		check("settings", 16'hFFEC, rdata);
		do_op(OP_HW_RESET, 22'h0, 16'h0);
		do_op(OP_VPB_READ, B1, 16'h0);
		check("vol after reset", 16'h0000, rdata);
		$display("settings test done");
		do_op(OP_PERSISTENT_BLOCK_GUARD_BIT_PROG, B1, 16'h0);
		do_op(OP_GLB_SET, 22'h0, 16'h0);
		do_op(OP_GLB_READ, 22'h0, 16'h0);
		check("lock", 16'h0000, rdata);
		do_op(OP_PERSISTENT_BLOCK_GUARD_BIT_ERASE, B1, 16'h0);
		do_op(OP_PERSISTENT_BLOCK_GUARD_BIT_READ, B1, 16'h0);
		check("frozen bit", 16'h0000, rdata);
		do_op(OP_HW_RESET, 22'h0, 16'h0);
		do_op(OP_GLB_READ, 22'h0, 16'h0);
		check("lock after reset", 16'h0001, rdata);
		do_op(OP_PERSISTENT_BLOCK_GUARD_BIT_READ, B1, 16'h0);
		check("kept bit", 16'h0000, rdata);
		$display("lock test done");
		slow = 1'b1;
		do_op(OP_PSR_READ, 22'h0, 16'h0);
		check("slow read", 16'hFFEC, rdata);
		$display("slow test done");
		// Reset in mid-sequence must drop every strobe at once
		req = '{OP_VPB_SET, B1, 16'h0};
		valid = 1'b1;
		@(posedge clk_sys) #2;
		valid = 1'b0;
		repeat (3) @(posedge clk_sys);
		#2 reset_n = 1'b0;
		check("busy mid-run", 16'h1, {15'h0, busy});
		@(posedge clk_sys) #2;
		check("busy after reset", 16'h0, {15'h0, busy});
		check("strobes after reset", 16'h7, {13'h0, ce_n, we_n, oe_n});
		reset_n = 1'b1;
		@(posedge clk_sys) #2;
		check("ready after reset", 16'h1, {15'h0, ready});
		$display("reset test done");
		stop_test();
	end
endmodule
